// file: design/esic_cfg.svh
// Constants of the eight-source interrupt controller.
// Assumes inclusion by esic_top only.
`ifndef ESIC_CFG_SVH
`define ESIC_CFG_SVH
// ==========================================
// Register addresses
`define ESIC_XC_ADDR 8'hC0
`define ESIC_P4_ADDR 8'hD8
// ==========================================
// Extra control register fields
`define ESIC_IT2 0
`define ESIC_IE2 1
`define ESIC_EX2 2
`define ESIC_PX2 3
`define ESIC_IT3 4
`define ESIC_IE3 5
`define ESIC_EX3 6
`define ESIC_PX3 7
// ==========================================
// Core register fields
`define ESIC_EA 7
`define ESIC_IT0 0
`define ESIC_IT1 2
// ==========================================
// Reset values, vector low bits, source indices and bit address
`define ESIC_XC_RST 8'h00
`define ESIC_P4_RST 4'hF
`define ESIC_VEC_LOW 3'h3
`define ESIC_SRC_X2 3'h6
`define ESIC_SRC_X3 3'h7
`define ESIC_BIT_X2EN 8'hC2
`endif

// file: design/esic_pkg.sv
// Types of the eight-source interrupt controller.
// Assumes esic_cfg.svh on the include path.
package esic_pkg;
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] flt;
        logic [3:0] lin;
        logic [7:0] xc;
        logic [3:0] lat;
        logic [3:0] pend;
        logic in_hi;
        logic in_lo;
        logic req;
        logic [2:0] idx;
        logic [7:0] vec;
        logic lvl;
        logic [7:0] rd;
        logic wake;
    } esic_state_t;
endpackage : esic_pkg

// file: design/esic_top.sv
// Eight-source two-level interrupt controller with extra nibble port.
// Assumes a core that owns enable, priority and timer control registers.
// Function
// - extra control register sits at C0H
// - enable of source two is bit 2
// - priority bit selects high or low
// - requests ignored while enable bit cleared
// - trigger bit picks falling edge or level
// - edge pending set on edge, cleared on service
// - eight vectors 03H to 3BH in order
// - fixed polling order within one level
// - standard enables and external zero/one trigger bits
// - four-bit port at D8H like port one
// - port pins 2 and 3 double as requests
// - enabled request releases idle mode
`timescale 1ns/100ps
`include "esic_cfg.svh"
module esic_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_val,
    output logic [7:0] sfr_rdata,
    input wire logic [7:0] std_irq_enable_reg,
    input wire logic [5:0] std_irq_priority,
    input wire logic [7:0] timer_control_reg,
    input wire logic [3:0] std_req,
    input wire logic ext_request_zero_pin_n,
    input wire logic ext_request_one_pin_n,
    input wire logic [3:0] extra_nibble_port_in,
    output logic [3:0] extra_nibble_port_out,
    output logic [3:0] extra_nibble_port_oe_n,
    output logic irq_req,
    output logic [7:0] irq_vector,
    output logic irq_level,
    input wire logic irq_ack,
    input wire logic irq_reti,
    output logic idle_wake
);
    import esic_pkg::*;

    esic_state_t q;
    esic_state_t d;

    // ==========================================
    // Helpers
    function automatic logic esic_hit(input logic [7:0] base, input logic w, input logic [7:0] a,
                                      input logic bw, input logic [7:0] ba);
        esic_hit = (w && a == base) || (bw && ba[7:3] == base[7:3]);
    endfunction : esic_hit

    function automatic logic [7:0] esic_apply(input logic [7:0] old, input logic w,
                                              input logic [7:0] wd, input logic bw,
                                              input logic [7:0] ba, input logic bv);
        logic [7:0] r;
        r = old;
        if (bw) begin
            r[ba[2:0]] = bv;
        end else if (w) begin
            r = wd;
        end
        esic_apply = r;
    endfunction : esic_apply

    function automatic logic [2:0] esic_first(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        esic_first = r;
    endfunction : esic_first

    // ==========================================
    // Source lines and requests
    logic [3:0] line;
    logic [3:0] fall;
    logic [3:0] itype;
    logic [7:0] xcur;
    logic [7:0] xnew;
    logic [7:0] pnew;
    logic xsw;
    logic psw;
    logic [7:0] ackv;
    logic [3:0] ackx;
    logic [7:0] srcreq;
    logic [7:0] prio;
    logic [7:0] hi;
    logic [7:0] lo;

    assign line = {~q.lat[3] | q.flt[3], ~q.lat[2] | q.flt[2], q.flt[5], q.flt[4]};
    assign fall = q.lin & ~line;
    assign itype = {q.xc[`ESIC_IT3], q.xc[`ESIC_IT2], timer_control_reg[`ESIC_IT1],
                    timer_control_reg[`ESIC_IT0]};
    assign xcur = {q.xc[7:6], q.pend[3], q.xc[4:2], q.pend[2], q.xc[0]};
    assign xsw = esic_hit(`ESIC_XC_ADDR, sfr_wr, sfr_addr, sfr_bit_wr, sfr_bit_addr);
    assign xnew = esic_apply(xcur, sfr_wr, sfr_wdata, sfr_bit_wr, sfr_bit_addr, sfr_bit_val);
    assign psw = esic_hit(`ESIC_P4_ADDR, sfr_wr, sfr_addr, sfr_bit_wr, sfr_bit_addr);
    assign pnew = esic_apply({4'h0, q.lat}, sfr_wr, sfr_wdata, sfr_bit_wr, sfr_bit_addr, sfr_bit_val);
    assign ackv = (irq_ack && q.req) ? (8'h01 << q.idx) : 8'h00;
    assign ackx = {ackv[7], ackv[6], ackv[2], ackv[0]};
    assign srcreq = {q.pend[3], q.pend[2], std_req[3], std_req[2], std_req[1], q.pend[1],
                     std_req[0], q.pend[0]}
                    & {q.xc[`ESIC_EX3], q.xc[`ESIC_EX2], std_irq_enable_reg[5:0]}
                    & {8{std_irq_enable_reg[`ESIC_EA]}};
    assign prio = {q.xc[`ESIC_PX3], q.xc[`ESIC_PX2], std_irq_priority};
    assign hi = srcreq & prio;
    assign lo = srcreq & ~prio;

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        // Pin synchroniser, change taken once stages two and three agree
        d.s1 = {ext_request_one_pin_n, ext_request_zero_pin_n, extra_nibble_port_in};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 6; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.flt[i] = q.s3[i];
            end
        end
        d.lin = line;
        // Pending flags, hardware set wins over any clear
        for (int k = 0; k < 4; k++) begin
            if (itype[k]) begin
                if (k >= 2 && xsw) begin
                    d.pend[k] = fall[k] | xnew[k == 2 ? `ESIC_IE2 : `ESIC_IE3];
                end else begin
                    d.pend[k] = fall[k] | (q.pend[k] & ~ackx[k]);
                end
            end else begin
                d.pend[k] = ~line[k];
            end
        end
        if (xsw) begin
            d.xc = xnew;
        end
        if (psw) begin
            d.lat = pnew[3:0];
        end
        // In-service levels
        if (irq_ack && q.req) begin
            if (q.lvl) begin
                d.in_hi = 1'b1;
            end else begin
                d.in_lo = 1'b1;
            end
        end else if (irq_reti) begin
            if (q.in_hi) begin
                d.in_hi = 1'b0;
            end else begin
                d.in_lo = 1'b0;
            end
        end
        // Arbitration, high preempts low only
        d.req = 1'b0;
        d.lvl = 1'b0;
        d.idx = 3'h0;
        if (|hi && !d.in_hi) begin
            d.req = 1'b1;
            d.lvl = 1'b1;
            d.idx = esic_first(hi);
        end else if (|lo && !d.in_hi && !d.in_lo) begin
            d.req = 1'b1;
            d.idx = esic_first(lo);
        end
        d.vec = {2'b00, d.idx, `ESIC_VEC_LOW};
        d.wake = |srcreq;
        // Read path, unmapped reads return zero
        case (sfr_addr)
            `ESIC_XC_ADDR: d.rd = xcur;
            `ESIC_P4_ADDR: d.rd = {4'h0, q.flt[3:0]};
            default: d.rd = 8'h00;
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.s1 <= 6'h3F;
            q.s2 <= 6'h3F;
            q.s3 <= 6'h3F;
            q.flt <= 6'h3F;
            q.lin <= 4'hF;
            q.xc <= `ESIC_XC_RST;
            q.lat <= `ESIC_P4_RST;
        end else begin
            q <= d;
        end
    end

    assign sfr_rdata = q.rd;
    assign extra_nibble_port_out = q.lat;
    assign extra_nibble_port_oe_n = q.lat;
    assign irq_req = q.req;
    assign irq_vector = q.vec;
    assign irq_level = q.lvl;
    assign idle_wake = q.wake;

    // ==========================================
    // Checks
    xc_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sfr_wr && !sfr_bit_wr && sfr_addr == `ESIC_XC_ADDR) |=> q.xc[`ESIC_EX3] == $past(sfr_wdata[6]))
        else $error("control byte write lost");
    bit_enable_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sfr_bit_wr && sfr_bit_addr == `ESIC_BIT_X2EN) |=> q.xc[`ESIC_EX2] == $past(sfr_bit_val))
        else $error("bit set of enable lost");
    prio_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.req && q.idx == `ESIC_SRC_X2) |-> q.lvl == $past(q.xc[`ESIC_PX2]))
        else $error("source two at wrong level");
    enable_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.req && q.idx == `ESIC_SRC_X2) |-> $past(q.xc[`ESIC_EX2]))
        else $error("disabled source granted");
    edge_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (itype[2] && fall[2]) |=> q.pend[2])
        else $error("edge not latched");
    level_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !itype[2] |=> q.pend[2] == !$past(line[2]))
        else $error("level flag not following pin");
    ack_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ackx[2] && itype[2] && !fall[2] && !xsw) |=> !q.pend[2])
        else $error("service did not clear flag");
    vector_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.req |-> q.vec == {2'b00, q.idx, `ESIC_VEC_LOW})
        else $error("vector mismatch");
    preempt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.req |-> !q.in_hi && (q.lvl || !q.in_lo))
        else $error("request at blocked level");
    wake_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (|srcreq) |=> q.wake)
        else $error("idle wake missed");
    port_latch_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sfr_wr && !sfr_bit_wr && sfr_addr == `ESIC_P4_ADDR) |=> q.lat == $past(sfr_wdata[3:0]))
        else $error("port latch write lost");
    port_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sfr_addr == `ESIC_P4_ADDR) |=> q.rd == {4'h0, $past(q.flt[3:0])})
        else $error("port read not pin level");
    enable_three_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.req && q.idx == `ESIC_SRC_X3) |-> $past(q.xc[`ESIC_EX3]))
        else $error("disabled source three granted");
    edge_three_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (itype[3] && fall[3]) |=> q.pend[3])
        else $error("edge three not latched");
    hi_service_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (irq_ack && q.req && q.lvl) |=> q.in_hi)
        else $error("high service not marked");
    hi_return_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (irq_reti && !irq_ack && q.in_hi) |=> !q.in_hi)
        else $error("high service not released");
endmodule : esic_top

// file: verif/esic_board_src.sv
// Board devices that pull the four request lines.
// Assumes the bench calls its tasks after a falling edge.
`timescale 1ns/100ps
module esic_board_src (
    input wire logic sys_clk,
    output logic [3:0] line_n
);
    // ==========================================
    // Line control
    initial line_n = 4'hF;
    // Each level held four samples
    task automatic pulse(input int i);
        line_n[i] = 1'b0;
        repeat (4) @(negedge sys_clk);
        line_n[i] = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : pulse
    task automatic hold(input int i, input logic v);
        line_n[i] = v;
        @(negedge sys_clk);
    endtask : hold
    task automatic free();
        line_n = 4'hF;
    endtask : free
endmodule : esic_board_src

// file: verif/tb_eight_source_interrupt_ctrl.sv
// Bench for the eight-source interrupt controller.
// Assumes esic_top and esic_board_src compiled first.
`timescale 1ns/100ps
module tb_eight_source_interrupt_ctrl;
    // ==========================================
    // Signals
    logic sys_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
    logic sfr_bit_val = 1'b0, irq_ack = 1'b0, irq_reti = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00;
    logic [7:0] std_irq_enable_reg = 8'hBF, timer_control_reg = 8'h00;
    logic [5:0] std_irq_priority = 6'h00;
    logic [3:0] std_req = 4'h0;
    logic [7:0] sfr_rdata, irq_vector;
    logic [3:0] extra_nibble_port_out, extra_nibble_port_oe_n, line_n;
    logic irq_req, irq_level, idle_wake;
    int n_fail = 0;
    int check_count = 0;
    // Address, write data, read back
    localparam logic [23:0] ROWS [6] = '{24'hC0_44_44, 24'hC0_99_99, 24'hD8_0A_0A,
                                         24'hD8_0F_0F, 24'h55_3C_00, 24'hC0_00_00};
    // Source to line (0..3) or standard request bit plus 4
    localparam int MAP [8] = '{0, 4, 1, 5, 6, 7, 2, 3};
    always #5 sys_clk = ~sys_clk;
    esic_board_src src (.sys_clk, .line_n);
    // Port pins pulled up; latch or board pulls low
    esic_top dut (
        .sys_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_addr,
        .sfr_bit_val, .sfr_rdata, .std_irq_enable_reg, .std_irq_priority,
        .timer_control_reg, .std_req, .ext_request_zero_pin_n(line_n[0]),
        .ext_request_one_pin_n(line_n[1]),
        .extra_nibble_port_in(extra_nibble_port_oe_n & {line_n[3:2], 2'b11}),
        .extra_nibble_port_out, .extra_nibble_port_oe_n, .irq_req, .irq_vector,
        .irq_level, .irq_ack, .irq_reti, .idle_wake
    );
    // ==========================================
    // Tasks
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        idle(1);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        idle(2);
        chk(sfr_rdata, exp);
    endtask : rdchk
    task automatic irqchk(input logic lvl, input logic [7:0] vec);
        chk({6'h00, irq_req, irq_level}, {6'h00, 1'b1, lvl});
        chk(irq_vector, vec);
    endtask : irqchk
    task automatic strobe(input logic ret);
        irq_ack = !ret;
        irq_reti = ret;
        idle(1);
        irq_ack = 1'b0;
        irq_reti = 1'b0;
        idle(3);
    endtask : strobe
    task automatic print_verdict();
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // Sequence
    initial begin
        idle(8);
        rstn = 1'b1;
        chk(sfr_rdata, 8'h00);
        chk({extra_nibble_port_out, extra_nibble_port_oe_n}, 8'hFF);
        chk({6'h00, irq_req, idle_wake}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(ROWS[i][23:16], ROWS[i][15:8]);
            idle(6);
            rdchk(ROWS[i][23:16], ROWS[i][7:0]);
            if (ROWS[i][23:16] == 8'hD8) chk({4'h0, extra_nibble_port_out}, {4'h0, ROWS[i][11:8]});
        end
        sfr_bit_addr = 8'hC2;
        sfr_bit_val = 1'b1;
        sfr_bit_wr = 1'b1;
        idle(1);
        sfr_bit_wr = 1'b0;
        rdchk(8'hC0, 8'h04);
        wr(8'hC0, 8'h44);
        for (int j = 0; j < 8; j++) begin
            if (MAP[j] > 3) std_req[MAP[j] - 4] = 1'b1;
            else src.hold(MAP[j], 1'b0);
            idle(10);
            irqchk(1'b0, {2'b00, j[2:0], 3'h3});
            chk({7'h00, idle_wake}, 8'h01);
            std_req = 4'h0;
            src.free();
            idle(10);
        end
        wr(8'hC0, 8'h05);
        src.pulse(2);
        irqchk(1'b0, 8'h33);
        rdchk(8'hC0, 8'h07);
        strobe(1'b0);
        rdchk(8'hC0, 8'h05);
        strobe(1'b1);
        wr(8'hC0, 8'h08);
        src.hold(2, 1'b0);
        idle(10);
        chk({6'h00, irq_req, idle_wake}, 8'h00);
        std_req = 4'h1;
        wr(8'hC0, 8'h04);
        idle(3);
        irqchk(1'b0, 8'h0B);
        strobe(1'b0);
        chk({7'h00, irq_req}, 8'h00);
        wr(8'hC0, 8'h0C);
        idle(3);
        irqchk(1'b1, 8'h33);
        src.free();
        idle(10);
        strobe(1'b1);
        irqchk(1'b0, 8'h0B);
        std_req = 4'h0;
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
endmodule : tb_eight_source_interrupt_ctrl
